// >>> acsrc_pkg.sv
// Constants, register map and state encoding of the converter control
// block. Assumes one module clock, which also paces the converter steps.
//
// Operation
// - Converter stays powered off after reset
// - analog_off powers down; zero keeps enabled
// - Offset and gain calibration alternate per calibration run
// - State field shows startup calibration completion
// - Startup calibration lasts 1920 converter cycles
// - Calibration runs before, after, or disabled
// - Idle timer counts 128 times (max+1)
// - load_event_sw write starts source directly
// - Gate signal blocks conversion requests
// - Single-shot once per trigger; autoscan repeats
// - Trigger from 15 inputs, gate from 16
// - Scan descends from highest pending channel
// - Overwrite mode copies select into pending
// - Combine mode ORs select into pending
// - Conversion start clears its pending bit
// - Last conversion with none pending signals done
// - Autoscan turns done into new load
// - Pending write copies select, loads automatically
// - Inactive gate keeps pending bits intact
// - Gate mode 00 disables; pending_clear empties
// - Done sets flag; software set and clear
// - Pulse chosen service request line on event
package acsrc_pkg;

   // ==========================================================
   // Sizes
   localparam int CH_N    = 8;
   localparam int CH_W    = 3;
   localparam int TRIG_N  = 15;
   localparam int GATE_N  = 16;
   localparam int SEL_W   = 4;
   localparam int NODE_N  = 4;
   localparam int NODE_W  = 2;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CONV_CFG  = 8'h00;
   localparam logic [7:0] OFF_GLOB_CFG  = 8'h04;
   localparam logic [7:0] OFF_CAL_CTRL  = 8'h08;
   localparam logic [7:0] OFF_TRIG_CTRL = 8'h0c;
   localparam logic [7:0] OFF_MODE_CTRL = 8'h10;
   localparam logic [7:0] OFF_CH_SEL    = 8'h14;
   localparam logic [7:0] OFF_CH_PEND   = 8'h18;
   localparam logic [7:0] OFF_EVT_FLAG  = 8'h1c;
   localparam logic [7:0] OFF_EVT_NODE  = 8'h20;

   // ==========================================================
   // Field positions
   localparam int F_ANALOG_OFF = 0;   // converter_cfg_reg
   localparam int F_CAL_MODE   = 4;   // converter_cfg_reg, 2 bits
   localparam int F_CAL_STATE  = 8;   // converter_cfg_reg, 2 bits, RO
   localparam int F_STARTUP_CAL_START      = 0;   // global_cfg_reg and calib_ctrl_reg
   localparam int F_CAL_MAX    = 8;   // calib_ctrl_reg, 8 bits
   localparam int F_TRIG_SEL   = 0;   // scan_trigger_ctrl, 4 bits
   localparam int F_TRIG_EDGE  = 4;   // scan_trigger_ctrl, 2 bits
   localparam int F_GATE_SEL   = 8;   // scan_trigger_ctrl, 4 bits
   localparam int F_GATE_MODE  = 0;   // scan_mode_ctrl, 2 bits
   localparam int F_TRIG_EN    = 2;
   localparam int F_AUTOSCAN   = 3;
   localparam int F_MERGE      = 4;
   localparam int F_PEND_CLR   = 8;   // write 1 only
   localparam int F_LOAD_SW    = 9;   // write 1 only
   localparam int F_FLAG       = 0;   // event_flag_reg: read flag, w1 set
   localparam int F_FLAG_CLR   = 16;  // event_flag_reg: w1 clear
   localparam int F_NODE       = 0;   // event_node_pointer, 2 bits
   localparam int F_IRQ_EN     = 4;

   // ==========================================================
   // Reset values
   localparam logic       RST_ANALOG_OFF = 1'b1;
   localparam logic [7:0] RST_CAL_MAX    = 8'hff;

   // ==========================================================
   // Encodings
   localparam logic [1:0] CAL_AFTER    = 2'h0;
   localparam logic [1:0] CAL_BEFORE   = 2'h1;
   localparam logic [1:0] CAL_DISABLED = 2'h2;
   localparam logic [1:0] CST_NONE     = 2'h0;
   localparam logic [1:0] CST_RUNNING  = 2'h1;
   localparam logic [1:0] CST_READY    = 2'h2;
   localparam logic [1:0] GATE_OFF     = 2'h0;
   localparam logic [1:0] GATE_ALWAYS  = 2'h1;
   localparam logic [1:0] GATE_HIGH    = 2'h2;
   localparam logic [1:0] GATE_LOW     = 2'h3;
   localparam logic [1:0] EDGE_NONE    = 2'h0;
   localparam logic [1:0] EDGE_RISE    = 2'h1;
   localparam logic [1:0] EDGE_FALL    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;

   // ==========================================================
   // Timing counts (converter cycles)
   localparam logic [10:0] STARTUP_CAL_START_CYCLES  = 11'd1920;
   localparam logic [3:0]  OFFSET_CYCLES = 4'd9;
   localparam logic [3:0]  GAIN_CYCLES   = 4'd12;
   localparam int          IDLE_PRESCALE = 128;
   localparam logic [6:0]  IDLE_PRE_FILL = 7'(IDLE_PRESCALE - 1);

   // ==========================================================
   // Stepper states, Gray along idle-conv-cal
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CONV  = 2'b01,
      ST_CAL   = 2'b11,
      ST_STARTUP_CAL_START = 2'b10
   } acsrc_state_t;

endpackage : acsrc_pkg

// >>> acsrc_ctrl.sv
// Converter power, calibration stepper and channel scan request source.
// Assumes a converter that takes conv_start with conv_channel and
// answers with a conv_done pulse; trigger and gate pins are asynchronous.
module acsrc_ctrl (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   // Register port
   input  wire logic [acsrc_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [acsrc_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [acsrc_pkg::DATA_W-1:0]  reg_rdata,
   // Trigger and gate pins
   input  wire logic [acsrc_pkg::TRIG_N-1:0]  trigger_inputs,
   input  wire logic [acsrc_pkg::GATE_N-1:0]  gating_inputs,
   // Converter side
   output logic                               analog_power_on,
   output logic                               conv_start,
   output logic      [acsrc_pkg::CH_W-1:0]    conv_channel,
   input  wire logic                          conv_done,
   output logic                               cal_run,
   output logic                               cal_gain,
   // Service requests
   output logic      [acsrc_pkg::NODE_N-1:0]  service_request_line
);
   import acsrc_pkg::*;

   // ==========================================================
   // Decoders
   function automatic logic [CH_N-1:0] dec_onehot(input logic [CH_W-1:0] i);
      dec_onehot = '0;
      dec_onehot[i] = 1'b1;
   endfunction : dec_onehot

   function automatic logic [CH_W-1:0] top_channel(input logic [CH_N-1:0] p);
      top_channel = '0;
      for (int k = 0; k < CH_N; k++) begin
         if (p[k]) begin
            top_channel = CH_W'(k);
         end
      end
   endfunction : top_channel

   // ==========================================================
   // Registers and state
   logic                analog_off;
   logic [1:0]          cal_mode;
   logic [1:0]          cal_state;
   logic [7:0]          cal_max;
   logic [SEL_W-1:0]    trig_sel;
   logic [1:0]          trig_edge;
   logic [SEL_W-1:0]    gate_sel;
   logic [1:0]          gate_mode;
   logic                trig_en;
   logic                autoscan;
   logic                merge;
   logic [CH_N-1:0]     ch_sel;
   logic [CH_N-1:0]     ch_pend;
   logic                evt_flag;
   logic [NODE_W-1:0]   node_ptr;
   logic                irq_en;
   acsrc_state_t        state;
   acsrc_state_t        next_state;
   logic [10:0]         startup_cal_start_cnt;
   logic [3:0]          cal_cnt;
   logic                cal_fresh;
   logic                cal_due;
   logic [14:0]         idle_cnt;
   logic [TRIG_N-1:0]   trig_s1;
   logic [TRIG_N-1:0]   trig_s2;
   logic [TRIG_N-1:0]   trig_s3;
   logic [GATE_N-1:0]   gate_s1;
   logic [GATE_N-1:0]   gate_s2;

   // ==========================================================
   // Write decode
   wire wr_conv  = reg_wr & (reg_addr == OFF_CONV_CFG);
   wire wr_glob  = reg_wr & (reg_addr == OFF_GLOB_CFG);
   wire wr_cal   = reg_wr & (reg_addr == OFF_CAL_CTRL);
   wire wr_trig  = reg_wr & (reg_addr == OFF_TRIG_CTRL);
   wire wr_mode  = reg_wr & (reg_addr == OFF_MODE_CTRL);
   wire wr_sel   = reg_wr & (reg_addr == OFF_CH_SEL);
   wire wr_pend  = reg_wr & (reg_addr == OFF_CH_PEND);
   wire wr_flag  = reg_wr & (reg_addr == OFF_EVT_FLAG);
   wire wr_node  = reg_wr & (reg_addr == OFF_EVT_NODE);

   // Write-one actions
   wire startup_cal_start_req = (wr_glob | wr_cal) & reg_wdata[F_STARTUP_CAL_START];
   wire pend_clr  = wr_mode & reg_wdata[F_PEND_CLR];
   wire sw_load   = wr_mode & reg_wdata[F_LOAD_SW];
   wire flag_set  = wr_flag & reg_wdata[F_FLAG];
   wire flag_clr  = wr_flag & reg_wdata[F_FLAG_CLR];

   // ==========================================================
   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         trig_s1 <= '0;
         trig_s2 <= '0;
         trig_s3 <= '0;
         gate_s1 <= '0;
         gate_s2 <= '0;
      end else begin
         trig_s1 <= trigger_inputs;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         gate_s1 <= gating_inputs;
         gate_s2 <= gate_s1;
      end
   end

   // ==========================================================
   // Trigger edge and gate selection
   // Select code 15 has no trigger behind it and reads as low
   wire [GATE_N-1:0] trig_now = {1'b0, trig_s2};
   wire [GATE_N-1:0] trig_old = {1'b0, trig_s3};
   wire trig_lvl  = trig_now[trig_sel];
   wire trig_prev = trig_old[trig_sel];
   wire trig_rise = trig_lvl & ~trig_prev;
   wire trig_fall = ~trig_lvl & trig_prev;
   wire trig_hit  = ((trig_edge == EDGE_RISE) & trig_rise) |
                    ((trig_edge == EDGE_FALL) & trig_fall) |
                    ((trig_edge == EDGE_BOTH) & (trig_rise | trig_fall));
   wire hw_load   = trig_en & trig_hit;
   wire gate_lvl  = gate_s2[gate_sel];
   // Gate only withholds requests; pending bits are untouched
   wire gate_ok   = (gate_mode == GATE_ALWAYS) |
                    ((gate_mode == GATE_HIGH) & gate_lvl) |
                    ((gate_mode == GATE_LOW) & ~gate_lvl);

   // ==========================================================
   // Request issue and sequence end
   wire ready     = ~analog_off & (cal_state == CST_READY);
   wire req_ok    = ready & gate_ok & (ch_pend != '0) & ~cal_due;
   wire need_pre  = (cal_mode == CAL_BEFORE) & ~cal_fresh;
   wire issue     = (state == ST_IDLE) & req_ok & ~need_pre;
   wire [CH_W-1:0] issue_ch = top_channel(ch_pend);
   wire in_conv   = (state == ST_CONV);
   wire src_done  = in_conv & conv_done & (ch_pend == '0);
   wire conv_end  = in_conv & conv_done;
   wire cal_end   = (state == ST_CAL) & (cal_cnt == 4'd1);
   wire startup_cal_start_end = (state == ST_STARTUP_CAL_START) & (startup_cal_start_cnt == 11'd1);

   // ==========================================================
   // Pending bit update: issue clears, then clear, then load
   wire auto_load = src_done & autoscan;
   wire load_evt  = sw_load | hw_load | wr_pend | auto_load;
   wire [CH_N-1:0] load_pat = wr_pend ? reg_wdata[CH_N-1:0] : ch_sel;
   wire [CH_N-1:0] issue_mask = issue ? dec_onehot(issue_ch) : '0;
   wire [CH_N-1:0] pend_base  = pend_clr ? '0 :
                                (ch_pend & ~issue_mask);
   wire [CH_N-1:0] next_pend  = ~load_evt ? pend_base :
                                merge ? (pend_base | load_pat) :
                                load_pat;

   // ==========================================================
   // Idle calibration timer enable and reload value
   wire timer_on  = ready & (cal_mode != CAL_DISABLED);
   wire timer_ld  = cal_end | startup_cal_start_end;
   wire [14:0] timer_init = {cal_max, IDLE_PRE_FILL};

   // ==========================================================
   // Stepper next state; power-down abandons any step
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (startup_cal_start_req & ~analog_off & (cal_state != CST_RUNNING)) begin
               next_state = ST_STARTUP_CAL_START;
            end else if (issue) begin
               next_state = ST_CONV;
            end else if (req_ok & need_pre) begin
               next_state = ST_CAL;
            end else if (cal_due & ready) begin
               next_state = ST_CAL;
            end
         end
         ST_STARTUP_CAL_START: begin
            if (startup_cal_start_end) begin
               next_state = ST_IDLE;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               next_state = (cal_mode == CAL_AFTER) ? ST_CAL : ST_IDLE;
            end
         end
         ST_CAL: begin
            if (cal_end) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (analog_off) begin
         next_state = ST_IDLE;
      end
   end

   // ==========================================================
   // Stepper, counters and calibration progress
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         startup_cal_start_cnt <= '0;
         cal_cnt   <= '0;
         cal_gain  <= 1'b0;
         cal_fresh <= 1'b0;
         cal_state <= CST_NONE;
      end else begin
         state <= next_state;
         if (next_state == ST_STARTUP_CAL_START && state != ST_STARTUP_CAL_START) begin
            startup_cal_start_cnt <= STARTUP_CAL_START_CYCLES;
            cal_state <= CST_RUNNING;
         end else if (state == ST_STARTUP_CAL_START) begin
            startup_cal_start_cnt <= startup_cal_start_cnt - 11'd1;
            if (analog_off) begin
               cal_state <= CST_NONE;
            end else if (startup_cal_start_end) begin
               cal_state <= CST_READY;
            end
         end
         if (next_state == ST_CAL && state != ST_CAL) begin
            cal_cnt <= cal_gain ? GAIN_CYCLES : OFFSET_CYCLES;
         end else if (state == ST_CAL) begin
            cal_cnt <= cal_cnt - 4'd1;
         end
         if (cal_end) begin
            cal_gain <= ~cal_gain;
         end
         if (issue) begin
            cal_fresh <= 1'b0;
         end else if (cal_end) begin
            cal_fresh <= 1'b1;
         end
      end
   end

   // Idle timer; a pending expiry waits for the stepper
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         idle_cnt <= '0;
         cal_due  <= 1'b0;
      end else if (timer_ld) begin
         idle_cnt <= timer_init;
         cal_due  <= 1'b0;
      end else if (timer_on && !cal_due) begin
         idle_cnt <= idle_cnt - 15'd1;
         cal_due  <= (idle_cnt == '0);
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         analog_off <= RST_ANALOG_OFF;
         cal_mode   <= CAL_AFTER;
         cal_max    <= RST_CAL_MAX;
         trig_sel   <= '0;
         trig_edge  <= EDGE_NONE;
         gate_sel   <= '0;
         gate_mode  <= GATE_OFF;
         trig_en    <= 1'b0;
         autoscan   <= 1'b0;
         merge      <= 1'b0;
         node_ptr   <= '0;
         irq_en     <= 1'b0;
      end else begin
         if (wr_conv) begin
            analog_off <= reg_wdata[F_ANALOG_OFF];
            cal_mode   <= reg_wdata[F_CAL_MODE +: 2];
         end
         if (wr_cal) begin
            cal_max <= reg_wdata[F_CAL_MAX +: 8];
         end
         if (wr_trig) begin
            trig_sel  <= reg_wdata[F_TRIG_SEL +: SEL_W];
            trig_edge <= reg_wdata[F_TRIG_EDGE +: 2];
            gate_sel  <= reg_wdata[F_GATE_SEL +: SEL_W];
         end
         if (wr_mode) begin
            gate_mode <= reg_wdata[F_GATE_MODE +: 2];
            trig_en   <= reg_wdata[F_TRIG_EN];
            autoscan  <= reg_wdata[F_AUTOSCAN];
            merge     <= reg_wdata[F_MERGE];
         end
         if (wr_node) begin
            node_ptr <= reg_wdata[F_NODE +: NODE_W];
            irq_en   <= reg_wdata[F_IRQ_EN];
         end
      end
   end

   // ==========================================================
   // Channel select and pending bits
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ch_sel  <= '0;
         ch_pend <= '0;
      end else begin
         if (wr_sel | wr_pend) begin
            ch_sel <= reg_wdata[CH_N-1:0];
         end
         ch_pend <= next_pend;
      end
   end

   // ==========================================================
   // Event flag: hardware set beats a same-cycle clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         evt_flag <= 1'b0;
      end else if (src_done | flag_set) begin
         evt_flag <= 1'b1;
      end else if (flag_clr) begin
         evt_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Converter request and service request pulses
   wire srq_fire = (src_done & irq_en) | flag_set;
   wire [CH_N-1:0] node_hot = dec_onehot({1'b0, node_ptr});
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         conv_start           <= 1'b0;
         conv_channel         <= '0;
         service_request_line <= '0;
         analog_power_on      <= 1'b0;
         cal_run              <= 1'b0;
      end else begin
         conv_start <= issue;
         if (issue) begin
            conv_channel <= issue_ch;
         end
         service_request_line <= srq_fire ? node_hot[NODE_N-1:0] : '0;
         analog_power_on      <= ~analog_off;
         cal_run              <= (next_state == ST_CAL) |
                                 (next_state == ST_STARTUP_CAL_START);
      end
   end

   // ==========================================================
   // Read mux; unmapped offsets read zero
   wire [DATA_W-1:0] rd_conv = DATA_W'({cal_state, 2'b00, cal_mode,
                                        3'b000, analog_off});
   wire [DATA_W-1:0] rd_cal  = DATA_W'({cal_max, 8'h00});
   wire [DATA_W-1:0] rd_trig = DATA_W'({gate_sel, 2'b00, trig_edge, trig_sel});
   wire [DATA_W-1:0] rd_mode = DATA_W'({merge, autoscan, trig_en, gate_mode});
   wire [DATA_W-1:0] rd_node = DATA_W'({irq_en, 2'b00, node_ptr});
   wire [DATA_W-1:0] rd_word =
      (reg_addr == OFF_CONV_CFG)  ? rd_conv :
      (reg_addr == OFF_CAL_CTRL)  ? rd_cal  :
      (reg_addr == OFF_TRIG_CTRL) ? rd_trig :
      (reg_addr == OFF_MODE_CTRL) ? rd_mode :
      (reg_addr == OFF_CH_SEL)    ? DATA_W'(ch_sel)  :
      (reg_addr == OFF_CH_PEND)   ? DATA_W'(ch_pend) :
      (reg_addr == OFF_EVT_FLAG)  ? DATA_W'(evt_flag) :
      (reg_addr == OFF_EVT_NODE)  ? rd_node : '0;

   // Data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_word : '0;
      end
   end

endmodule : acsrc_ctrl

// >>> acsrc_ctrl_sva.sv
// Checker on the top ports of the converter control block.
// Assumes one clock domain and the synchronous active-low reset.
module acsrc_ctrl_sva (
   // Clock and reset
   input wire logic                         clk_sys,
   input wire logic                         rst_n,
   // Register port
   input wire logic [acsrc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [acsrc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                         reg_wr,
   // Converter and service side
   input wire logic                         analog_power_on,
   input wire logic                         conv_start,
   input wire logic                         conv_done,
   input wire logic                         cal_run,
   input wire logic [acsrc_pkg::NODE_N-1:0] service_request_line
);
   import acsrc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [10:0] run_len;
   wire         off_bit = reg_wdata[F_ANALOG_OFF];
   // Length of the current calibration run
   always_ff @(posedge clk_sys) begin
      run_len <= (!rst_n || !cal_run) ? 11'h0 : run_len + 11'h1;
   end
   // ==========================================================
   // Properties
   a_power_follows_off: assert property (reg_wr &&
      reg_addr == OFF_CONV_CFG |-> ##2 analog_power_on == !$past(off_bit, 2))
      else $error("power misses off bit");
   a_cal_run_len: assert property ($fell(cal_run) |->
      run_len == 11'd1920 || run_len == 11'd9 || run_len == 11'd12)
      else $error("bad cal length");
   a_cal_no_conv: assert property (cal_run |-> !conv_start)
      else $error("start in cal");
   a_conv_powered: assert property (conv_start |-> analog_power_on)
      else $error("start while off");
   a_conv_one_pulse: assert property (conv_start |=> !conv_start)
      else $error("long start");
   a_done_gap: assert property (conv_done |=> !conv_start)
      else $error("start after done");
   a_srq_one_line: assert property ($onehot0(service_request_line))
      else $error("several lines");
   a_srq_one_cycle: assert property (|service_request_line |=>
      service_request_line == '0) else $error("long pulse");
   a_flag_set_srq: assert property (reg_wr &&
      reg_addr == OFF_EVT_FLAG && reg_wdata[F_FLAG] |->
      ##[1:2] $onehot(service_request_line))
      else $error("no set pulse");
   c_conv: cover property (conv_start);
   c_cal_end: cover property ($fell(cal_run));
   c_srq: cover property (|service_request_line);
endmodule : acsrc_ctrl_sva

bind acsrc_ctrl acsrc_ctrl_sva u_sva (
   .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .analog_power_on,
   .conv_start, .conv_done, .cal_run, .service_request_line
);

// >>> acsrc_ctrl_bench.sv
// Self-checking bench of the converter control block.
// Assumes the package and the checker file are compiled before it.
module acsrc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import acsrc_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd_val;
   logic [TRIG_N-1:0] trigger_inputs = '0;
   logic [GATE_N-1:0] gating_inputs = '0;
   logic analog_power_on, conv_start, cal_run, cal_gain, conv_done = 1'b0;
   logic [CH_W-1:0]   conv_channel;
   logic [NODE_N-1:0] service_request_line, srq_seen = '0;
   logic [2:0]        busy = '0;
   int                errors = 0, compares = 0, starts = 0, srq_hits = 0;
   always #25 clk_sys = ~clk_sys;
   acsrc_ctrl u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .trigger_inputs, .gating_inputs, .analog_power_on,
      .conv_start, .conv_channel, .conv_done, .cal_run, .cal_gain,
      .service_request_line);
   // Converter stand-in answers four cycles late; also count pulses
   always @(posedge clk_sys) begin
      busy <= {busy[1:0], conv_start};
      conv_done <= busy[2];
      starts <= starts + int'(conv_start === 1'b1);
      srq_hits <= srq_hits + $countones(service_request_line);
      if (|service_request_line) srq_seen <= service_request_line;
   end
   // ==========================================================
   // Bus cycles and comparisons; the gap cycle keeps strobes clean
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      rd_val = reg_rdata;
      @(posedge clk_sys);
      chk(s, e, rd_val);
   endtask : rchk
   function automatic logic [31:0] top_ch(input logic [7:0] p);
      for (int i = 7; i >= 0; i--) if (p[i]) return i;
      return 0;
   endfunction : top_ch
   function automatic logic [31:0] cfg(input logic [1:0] st);
      return {22'h0, st, 2'h0, CAL_DISABLED, 4'h0};
   endfunction : cfg
   task automatic close_out;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // Watchdog: the whole sequence needs about 2700 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      close_out();
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] pa, pb;
      int t, g, nd, n;
      void'($urandom(19765));
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk("power", 32'h0, 32'(analog_power_on));
      rchk("conv cfg", OFF_CONV_CFG, 32'h1);
      rchk("cal ctrl", OFF_CAL_CTRL, {16'h0, RST_CAL_MAX, 8'h0});
      $display("reset test ended");
      wr(OFF_CONV_CFG, 32'(CAL_DISABLED) << F_CAL_MODE);
      wr(OFF_GLOB_CFG, 32'h1);
      chk("power", 32'h1, 32'(analog_power_on));
      rchk("cal state", OFF_CONV_CFG, cfg(CST_RUNNING));
      repeat (1916) @(posedge clk_sys);
      rchk("cal state", OFF_CONV_CFG, cfg(CST_RUNNING));
      rchk("cal state", OFF_CONV_CFG, cfg(CST_READY));
      $display("calibration test ended");
      for (int m = 0; m < 2; m++) begin
         pa = 8'($urandom_range(1, 255));
         pb = 8'($urandom_range(1, 255));
         wr(OFF_MODE_CTRL, 32'(m) << F_MERGE);
         wr(OFF_CH_PEND, {24'h0, pa});
         rchk("select", OFF_CH_SEL, {24'h0, pa});
         wr(OFF_CH_SEL, {24'h0, pb});
         wr(OFF_MODE_CTRL, (32'(m) << F_MERGE) | (32'h1 << F_LOAD_SW));
         rchk("load", OFF_CH_PEND, {24'h0, m ? pa | pb : pb});
         wr(OFF_MODE_CTRL, 32'h1 << F_PEND_CLR);
         rchk("clear", OFF_CH_PEND, 32'h0);
      end
      $display("load test ended");
      t = $urandom_range(0, TRIG_N - 1);
      wr(OFF_TRIG_CTRL, 32'(t) | (32'(EDGE_RISE) << F_TRIG_EDGE));
      wr(OFF_MODE_CTRL, 32'h1 << F_TRIG_EN);
      trigger_inputs[t] <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rchk("trigger", OFF_CH_PEND, {24'h0, pb});
      wr(OFF_MODE_CTRL, (32'h1 << F_TRIG_EN) | (32'h1 << F_PEND_CLR));
      trigger_inputs[t] <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rchk("fall", OFF_CH_PEND, 32'h0);
      $display("trigger test ended");
      for (int k = 0; k < 3; k++) begin
         g = $urandom_range(0, GATE_N - 1);
         nd = $urandom_range(0, NODE_N - 1);
         pa = 8'($urandom_range(1, 255));
         wr(OFF_EVT_NODE, 32'(nd) | (32'h1 << F_IRQ_EN));
         wr(OFF_TRIG_CTRL, 32'(g) << F_GATE_SEL);
         wr(OFF_MODE_CTRL, 32'(GATE_HIGH));
         wr(OFF_CH_PEND, {24'h0, pa});
         n = starts;
         repeat (20) @(posedge clk_sys);
         chk("gated", n, starts);
         rchk("gated", OFF_CH_PEND, {24'h0, pa});
         gating_inputs[g] <= 1'b1;
         n = srq_hits;
         while (pa != 0) begin
            t = 0;
            do begin
               @(negedge clk_sys);
               t++;
            end while (conv_start !== 1'b1 && t < 40);
            chk("channel", top_ch(pa), 32'(conv_channel));
            pa[top_ch(pa)] = 1'b0;
            @(posedge clk_sys);
         end
         repeat (10) @(posedge clk_sys);
         rchk("flag", OFF_EVT_FLAG, 32'h1);
         chk("srq", n + 1, srq_hits);
         chk("line", 32'h1 << nd, 32'(srq_seen));
         n = starts;
         repeat (20) @(posedge clk_sys);
         chk("single", n, starts);
         wr(OFF_EVT_FLAG, 32'h1 << F_FLAG_CLR);
         rchk("flag", OFF_EVT_FLAG, 32'h0);
         gating_inputs[g] <= 1'b0;
      end
      $display("scan test ended");
      n = srq_hits;
      wr(OFF_EVT_FLAG, 32'h0);
      rchk("flag", OFF_EVT_FLAG, 32'h0);
      wr(OFF_EVT_FLAG, 32'h1 << F_FLAG);
      rchk("flag", OFF_EVT_FLAG, 32'h1);
      chk("srq", n + 1, srq_hits);
      $display("flag test ended");
      n = starts;
      wr(OFF_MODE_CTRL, 32'(GATE_ALWAYS) | (32'h1 << F_AUTOSCAN));
      wr(OFF_CH_PEND, 32'h1);
      repeat (60) @(posedge clk_sys);
      chk("autoscan", 32'h1, 32'(starts - n > 4));
      wr(OFF_MODE_CTRL, 32'(GATE_OFF));
      n = starts;
      repeat (20) @(posedge clk_sys);
      chk("disabled", n, starts);
      wr(OFF_CAL_CTRL, 32'h0);
      wr(OFF_CONV_CFG, 32'h0);
      wr(OFF_CH_PEND, 32'h7);
      wr(OFF_MODE_CTRL, 32'(GATE_ALWAYS));
      repeat (60) @(posedge clk_sys);
      chk("after", n + 3, starts);
      chk("gain", 32'h1, 32'(cal_gain));
      repeat (200) @(posedge clk_sys);
      chk("idle", 32'h0, 32'(cal_gain));
      $display("autoscan test ended");
      close_out();
   end
endmodule : acsrc_ctrl_bench
